/* File: iowdt_top.sv */
// Watchdog timer reached through a single I/O port
`timescale 1ns/10ps
module iowdt_top #(
  parameter int unsigned TICK_CYCLES = iowdt_pkg::TICK_CYCLES,
  parameter int unsigned RESET_PULSE_CYCLES = iowdt_pkg::RESET_PULSE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic wdt_running,
  output logic sys_rst_n
);
  typedef enum logic [1:0] {IOWDT_IDLE, IOWDT_RUN, IOWDT_FIRE} iowdt_state_t;

  iowdt_state_t state_ff, nxt_state;
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic [5:0] sec_cnt_ff, nxt_sec_cnt;
  logic [5:0] ivl_ff, nxt_ivl;
  logic [7:0] rdata_ff, nxt_rdata;
  logic running_ff, nxt_running;
  logic rst_n_ff, nxt_rst_n;
  logic [7:0] pulse_cnt_ff, nxt_pulse_cnt;
  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [5:0] code;
  logic tick;
  logic wr_ok;
  logic [7:0] low_len_ff, nxt_low_len;

  // Zero lies outside the legal range, so it can never arm the countdown
  function automatic logic valid_code(input logic [5:0] c);
    valid_code = (c >= iowdt_pkg::INTERVAL_MIN) && (c <= iowdt_pkg::INTERVAL_MAX);
  endfunction

  function automatic logic last_second(input logic [5:0] s);
    last_second = (s == iowdt_pkg::INTERVAL_MIN);
  endfunction

  assign hit = (io_addr == iowdt_pkg::WDT_PORT_ADDR);
  assign wr_hit = hit && io_wr;
  assign rd_hit = hit && io_rd && !io_wr;
  assign code = io_wdata[5:0] & iowdt_pkg::INTERVAL_MASK;
  assign tick = (tick_cnt_ff == TICK_CYCLES - 1);
  assign wr_ok = wr_hit && valid_code(code);

  // Prescaler group: one enable pulse per second while counting
  always_comb begin
    nxt_tick_cnt = tick_cnt_ff;
    if (state_ff == IOWDT_RUN) begin
      nxt_tick_cnt = tick ? 32'h0 : tick_cnt_ff + 32'h1;
    end
    // A load restarts the second too, so a refresh buys whole seconds
    if ((wr_ok || rd_hit) && state_ff != IOWDT_FIRE) begin
      nxt_tick_cnt = 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= 32'h0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // Countdown group: state, seconds left, loaded interval, pulse length
  always_comb begin
    nxt_state = state_ff;
    nxt_sec_cnt = sec_cnt_ff;
    nxt_ivl = ivl_ff;
    nxt_pulse_cnt = pulse_cnt_ff;
    unique case (state_ff)
      IOWDT_IDLE, IOWDT_RUN: begin
        if (state_ff == IOWDT_RUN && tick) begin
          nxt_sec_cnt = sec_cnt_ff - 6'h01;
          if (last_second(sec_cnt_ff)) begin
            // Expired: raise the reset pulse
            nxt_state = IOWDT_FIRE;
            nxt_pulse_cnt = 8'h00;
          end
        end
        // A write in the expiry cycle wins: software refreshed in time
        if (wr_ok) begin
          nxt_state = IOWDT_RUN;
          nxt_ivl = code;
          nxt_sec_cnt = code;
        end else if (rd_hit) begin
          nxt_state = IOWDT_IDLE;
        end
      end
      IOWDT_FIRE: begin
        // Writes are ignored, and reads only update io_rdata, until the pulse has run its full length
        nxt_pulse_cnt = pulse_cnt_ff + 8'h01;
        if (pulse_cnt_ff == 8'(RESET_PULSE_CYCLES - 1)) begin
          nxt_state = IOWDT_IDLE;
        end
      end
      default: begin
        nxt_state = IOWDT_IDLE;
      end
    endcase
    nxt_running = (nxt_state == IOWDT_RUN);
    nxt_rst_n = (nxt_state != IOWDT_FIRE);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= IOWDT_IDLE;
      sec_cnt_ff <= 6'h00;
      ivl_ff <= 6'h00;
      running_ff <= 1'b0;
      rst_n_ff <= 1'b1;
      pulse_cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      sec_cnt_ff <= nxt_sec_cnt;
      ivl_ff <= nxt_ivl;
      running_ff <= nxt_running;
      rst_n_ff <= nxt_rst_n;
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end

  // Read data group: a read shows the last loaded interval
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_hit) begin
      nxt_rdata = {2'h0, ivl_ff};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Check-only counter: cycles spent in the current reset pulse
  always_comb begin
    nxt_low_len = rst_n_ff ? 8'h00 : low_len_ff + 8'h01;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_len_ff <= 8'h00;
    end else begin
      low_len_ff <= nxt_low_len;
    end
  end

  assign io_rdata = rdata_ff;
  assign wdt_running = running_ff;
  assign sys_rst_n = rst_n_ff;

  chk_write_starts: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_ok && state_ff != IOWDT_FIRE) |=> (wdt_running && sec_cnt_ff == $past(code)))
    else $error("valid interval write did not start countdown");
  chk_zero_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_hit && code == 6'h00 && state_ff == IOWDT_IDLE && !io_rd) |=> !wdt_running)
    else $error("zero interval started the watchdog");
  chk_refresh_reload: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_ff == IOWDT_RUN && wr_hit && code != 6'h00) |=> (tick_cnt_ff == 32'h0 && sys_rst_n))
    else $error("refresh did not reload the counter");
  chk_read_stops: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rd_hit && !wr_hit && state_ff != IOWDT_FIRE) |=> (!wdt_running ##1 sys_rst_n))
    else $error("read did not disable the watchdog");
  chk_expiry_fires: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_ff == IOWDT_RUN && tick && sec_cnt_ff == 6'h01 && !wr_hit && !rd_hit)
    |=> (!sys_rst_n && !wdt_running))
    else $error("expiry did not assert system reset");
  chk_fire_ends: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(sys_rst_n) |-> ##[1:300] sys_rst_n)
    else $error("reset pulse did not end");
  chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!wdt_running && sys_rst_n && !wr_hit) |=> sys_rst_n)
    else $error("reset raised while disabled");
  chk_count_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    wdt_running |-> (sec_cnt_ff >= iowdt_pkg::INTERVAL_MIN))
    else $error("second count out of range while running");

  chk_sec_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_ff == IOWDT_RUN && tick && !wr_hit && !rd_hit && !last_second(sec_cnt_ff))
    |=> (sec_cnt_ff == $past(sec_cnt_ff) - 6'h01))
    else $error("second count did not step down on the tick");
  chk_sec_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_ff == IOWDT_RUN && !tick && !wr_hit && !rd_hit) |=> $stable(sec_cnt_ff))
    else $error("second count moved between ticks");
  chk_tick_bound: assert property (@(posedge ref_clk) disable iff (!nrst)
    tick_cnt_ff < TICK_CYCLES)
    else $error("prescaler ran past one second");
  chk_other_port: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!hit && state_ff == IOWDT_IDLE) |=> !wdt_running)
    else $error("access to another port started the watchdog");
  chk_load_value: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wr_ok && state_ff != IOWDT_FIRE) |=> (ivl_ff == $past(code)))
    else $error("written interval was not loaded");
  chk_idle_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_ff == IOWDT_IDLE && !wr_ok) |=> !wdt_running)
    else $error("disabled watchdog started without a write");
  chk_rdata_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !rd_hit |=> $stable(io_rdata))
    else $error("read data changed without a read");
  chk_read_value: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_hit |=> (io_rdata == {2'h0, $past(ivl_ff)}))
    else $error("read did not return the loaded interval");
  chk_fire_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_ff == IOWDT_FIRE && pulse_cnt_ff != 8'(RESET_PULSE_CYCLES - 1)) |=> !sys_rst_n)
    else $error("reset pulse ended early");
  chk_pulse_len: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(sys_rst_n) |-> (low_len_ff == 8'(RESET_PULSE_CYCLES)))
    else $error("reset pulse length wrong");
  chk_fire_cause: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(sys_rst_n) |-> ($past(state_ff) == IOWDT_RUN && $past(tick)
    && $past(sec_cnt_ff) == iowdt_pkg::INTERVAL_MIN))
    else $error("reset pulse without expiry");
  chk_rst_stops: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sys_rst_n |-> !wdt_running)
    else $error("watchdog running during reset pulse");
endmodule // iowdt_top

/* File: iowdt_pkg.sv */
// Package of constants for the I/O port watchdog timer
package iowdt_pkg;
  localparam logic [15:0] WDT_PORT_ADDR = 16'h0444;
  localparam logic [5:0] INTERVAL_MIN = 6'h01;
  localparam logic [5:0] INTERVAL_MAX = 6'h3F;
  localparam logic [5:0] INTERVAL_MASK = 6'h3F;
  localparam int unsigned CLK_HZ = 32'h05F5E100;
  localparam int unsigned TICK_SEC = 32'h00000001;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;
  localparam int unsigned RESET_PULSE_CYCLES = 32'h00000010;
endpackage : iowdt_pkg

/* File: iowdt_top_tb.sv */
// Self-checking testbench for the I/O port watchdog timer
`timescale 1ns/10ps
module iowdt_top_tb;
  // Short second so that a 63 second countdown stays a few hundred cycles
  localparam int unsigned TICK = 32'h0000000A;
  localparam int unsigned PULSE = 32'h00000004;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic wdt_running;
  logic sys_rst_n;
  int n_fail = 0;
  int checks_done = 0;
  iowdt_top #(.TICK_CYCLES(TICK), .RESET_PULSE_CYCLES(PULSE)) iowdt_top_inst (
    .ref_clk(ref_clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .wdt_running(wdt_running),
    .sys_rst_n(sys_rst_n));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic wr);
    @(posedge ref_clk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = !wr;
    @(posedge ref_clk) #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask
  // Expiry must land exactly secs whole seconds after the accepted write
  task automatic expire(input int unsigned secs);
    repeat (secs * TICK - 1) @(posedge ref_clk);
    #1 chk_bit("reset out early", 1'b1, sys_rst_n);
    chk_bit("running before expiry", 1'b1, wdt_running);
    @(posedge ref_clk) #1;
    chk_bit("reset out fired", 1'b0, sys_rst_n);
    chk_bit("running after expiry", 1'b0, wdt_running);
    repeat (PULSE - 1) @(posedge ref_clk);
    #1 chk_bit("reset pulse held", 1'b0, sys_rst_n);
    @(posedge ref_clk) #1;
    chk_bit("reset pulse ended", 1'b1, sys_rst_n);
  endtask
  task automatic t_reset_state;
    chk("rdata at reset", 8'h00, io_rdata);
    chk_bit("running at reset", 1'b0, wdt_running);
    chk_bit("reset out at reset", 1'b1, sys_rst_n);
  endtask
  task automatic t_refused_writes;
    acc(16'h0444, 8'h00, 1'b1);
    chk_bit("running after code 0", 1'b0, wdt_running);
    acc(16'h0443, 8'h02, 1'b1);
    chk_bit("running after other port", 1'b0, wdt_running);
  endtask
  task automatic t_load_refresh;
    acc(16'h0444, 8'h02, 1'b1);
    chk_bit("running after load", 1'b1, wdt_running);
    repeat (TICK + 5) @(posedge ref_clk);
    #1 chk_bit("running before refresh", 1'b1, wdt_running);
    // Upper two bits set: must still mean three seconds
    acc(16'h0444, 8'hC3, 1'b1);
    expire(3);
  endtask
  task automatic t_read_disable;
    logic low_seen;
    low_seen = 1'b0;
    acc(16'h0444, 8'h3F, 1'b1);
    chk_bit("running after 3F", 1'b1, wdt_running);
    acc(16'h0444, 8'h00, 1'b0);
    chk("rdata after read", 8'h3F, io_rdata);
    chk_bit("running after read", 1'b0, wdt_running);
    // Watch every cycle: a reset pulse is far shorter than the wait
    repeat (64 * TICK) begin
      @(posedge ref_clk) #1;
      low_seen = low_seen | !sys_rst_n;
    end
    chk_bit("no expiry when disabled", 1'b0, low_seen);
    chk("rdata held", 8'h3F, io_rdata);
  endtask
  task automatic t_short_expiry;
    acc(16'h0444, 8'h01, 1'b1);
    expire(1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_reset_state();
    t_refused_writes();
    t_load_refresh();
    t_read_disable();
    t_short_expiry();
    wrap_up();
  end
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule // iowdt_top_tb
